// ### pwmts_pkg.sv
// pwmts_pkg: register map, field positions, reset values and carrier
// types for the channel 0 pwm timer block.
// assumes a 32-bit avalon-mm slave port with byte addresses.
package pwmts_pkg;

  // bus geometry
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int BE_W   = 4;
  localparam int CNT_W  = 16;
  localparam int REG_W  = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_START   = 6'h00;  // timer_start_control
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 6'h04;  // timer_status_zero
  localparam logic [ADDR_W-1:0] OFS_IEN     = 6'h08;  // timer_interrupt_enable_zero
  localparam logic [ADDR_W-1:0] OFS_IRQC    = 6'h0C;  // channel_zero_irq_control
  localparam logic [ADDR_W-1:0] OFS_DIS1    = 6'h10;  // output_master_disable_one
  localparam logic [ADDR_W-1:0] OFS_DIS2    = 6'h14;  // output_master_disable_two
  localparam logic [ADDR_W-1:0] OFS_COUNTER = 6'h18;  // channel_zero_counter
  localparam logic [ADDR_W-1:0] OFS_PERIOD  = 6'h1C;  // period_compare
  localparam logic [ADDR_W-1:0] OFS_CHG_B   = 6'h20;  // change point b
  localparam logic [ADDR_W-1:0] OFS_CHG_C   = 6'h24;  // change point c
  localparam logic [ADDR_W-1:0] OFS_CHG_D   = 6'h28;  // change_point_d_compare
  localparam logic [ADDR_W-1:0] OFS_CTRL    = 6'h2C;  // count source and clear select
  localparam logic [ADDR_W-1:0] OFS_POL     = 6'h30;  // pin polarity
  localparam logic [ADDR_W-1:0] OFS_INIT    = 6'h34;  // pin initial level

  // field positions
  localparam int START_GO_BIT    = 0;  // channel_zero_count_go
  localparam int DIS_A_BIT       = 0;  // pin_a_output_disable
  localparam int DIS_B_BIT       = 1;  // pin_b_output_disable
  localparam int DIS_C_BIT       = 2;  // pin_c_output_disable
  localparam int DIS_D_BIT       = 3;  // pin_d_output_disable
  localparam int CUTOFF_GATE_BIT = 7;  // forced_cutoff_gate_enable
  localparam int FLAG_A_BIT      = 0;  // compare_match_flag_a
  localparam int FLAG_B_BIT      = 1;
  localparam int FLAG_C_BIT      = 2;
  localparam int FLAG_D_BIT      = 3;
  localparam int FLAG_WRAP_BIT   = 4;  // counter_wrap_flag
  localparam int IRQ_LVL_LSB     = 0;  // irq_priority_bit0..2
  localparam int IRQ_LVL_W       = 3;
  localparam int IRQ_PEND_BIT    = 3;  // pending_request_flag
  localparam int SRC_LSB         = 0;  // count source select
  localparam int SRC_W           = 3;
  localparam int CLR_LSB         = 5;  // counter clear select
  localparam int CLR_W           = 3;
  localparam int POL_B_BIT       = 0;  // pin_b_polarity
  localparam int POL_C_BIT       = 1;
  localparam int POL_D_BIT       = 2;
  localparam int INIT_B_BIT      = 1;
  localparam int INIT_C_BIT      = 2;  // pin_c_initial_level
  localparam int INIT_D_BIT      = 3;

  // field values and masks
  localparam logic [CLR_W-1:0] CLR_SEL_PERIOD = 3'h1;
  localparam logic [REG_W-1:0] FLAG_MASK      = 8'h1F;
  localparam logic [REG_W-1:0] DIS_PWM_MASK   = 8'h0F;

  // reset values
  localparam logic [CNT_W-1:0] CNT_RST    = 16'h0000;
  localparam logic [CNT_W-1:0] CMP_RST    = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_TOP    = 16'hFFFF;
  localparam logic [REG_W-1:0] REG8_RST   = 8'h00;
  localparam logic [REG_W-1:0] CTRL_RST   = 8'h20;  // f1, clear on period match
  localparam logic [REG_W-1:0] DIS1_RST   = 8'h0F;  // all pins released
  localparam logic [REG_W-1:0] POL_RST    = 8'h07;  // active high
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  // one pin: level and output enable
  typedef struct packed {
    logic out;
    logic oe;
  } pwmts_pin_s;

  // per-channel static configuration
  typedef struct packed {
    logic polarity;
    logic init_level;
    logic disable_out;
    logic cutoff;
  } pwmts_chan_cfg_s;

endpackage

// ### pwmts_sync2.sv
// pwmts_sync2: two-flop synchroniser for asynchronous pin levels.
// assumes the inputs are levels that stay stable for several clocks.
`timescale 1ns/10ps
module pwmts_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         srst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } pwmts_sync_s;

  pwmts_sync_s state_reg;
  pwmts_sync_s state_next;

  // first stage feeds only the second stage
  always_comb begin
    state_next        = state_reg;
    state_next.meta   = async_in;
    state_next.stable = state_reg.meta;
  end

  // register the stages; reset to inactive (high) level
  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg <= '1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.stable;

endmodule

// ### pwmts_pwm_chan.sv
// pwmts_pwm_chan: one pwm output with its change-point compare.
// assumes counter and tick come from the channel 0 counter, same clock.
`timescale 1ns/10ps
module pwmts_pwm_chan #(
  parameter int CNT_W = 16
) (
  input  wire logic                     clock,
  input  wire logic                     srst,
  input  wire logic                     tick,
  input  wire logic                     restart,
  input  wire logic                     period_hit,
  input  wire logic [CNT_W-1:0]         counter,
  input  wire logic [CNT_W-1:0]         change_val,
  input  wire pwmts_pkg::pwmts_chan_cfg_s cfg,
  output pwmts_pkg::pwmts_pin_s         pin,
  output logic                          change_hit
);

  typedef struct packed {
    logic                 active;
    pwmts_pkg::pwmts_pin_s pin;
  } pwmts_chan_s;

  pwmts_chan_s state_reg;
  pwmts_chan_s state_next;

  // change-point match on a count tick
  assign change_hit = tick & (counter == change_val);

  // active state, pin level and enable
  always_comb begin
    state_next = state_reg;
    if (restart) begin
      state_next.active = cfg.init_level;  // RULE13
    end else if (period_hit) begin
      state_next.active = 1'b0;  // RULE14
    end else if (change_hit) begin
      state_next.active = 1'b1;  // RULE14
    end
    state_next.pin.out = ~(state_next.active ^ cfg.polarity);  // RULE12
    state_next.pin.oe  = ~cfg.disable_out & ~cfg.cutoff;  // RULE3
  end

  // register state; pin idles released and low
  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pin = state_reg.pin;

endmodule

// ### pwmts_top.sv
// pwmts_top: channel 0 pwm timer with period compare, three pwm pins,
// per-pin output disables, gated forced cutoff, flags and interrupt.
// assumes an avalon-mm master on the same clock and an async cutoff pin.
//
// Function
// [RULE1] 16-bit change point register for pin d
// [RULE2] disable bit 0 releases period pin
// [RULE3] bits 1-3 disable pins b, c, d
// [RULE4] bit 7 gates external cutoff input
// [RULE5] flag a cleared by read then write zero
// [RULE6] enable a lets flag a request interrupt
// [RULE7] start bit 0 runs the counter
// [RULE8] 3-bit priority plus read-only pending bit 3
// [RULE9] handler software must clear flag a
// [RULE10] counter increments, wrap sets overflow flag
// [RULE11] clear select 001 zeroes counter on period
// [RULE12] polarity bit 1 means active high
// [RULE13] initial level 0 starts inactive
// [RULE14] change match activates, period match deactivates
// [RULE15] period match sets flag a with clear
`timescale 1ns/10ps
module pwmts_top #(
  parameter int DIV_W = 8
) (
  input  wire logic                         clock,
  input  wire logic                         srst,
  input  wire logic [pwmts_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [pwmts_pkg::DATA_W-1:0] avs_writedata,
  input  wire logic [pwmts_pkg::BE_W-1:0]   avs_byteenable,
  output logic      [pwmts_pkg::DATA_W-1:0] avs_readdata,
  output logic                              avs_waitrequest,
  input  wire logic                         external_cutoff_input_n,
  output pwmts_pkg::pwmts_pin_s             period_pin,
  output pwmts_pkg::pwmts_pin_s             pwm_pin_b,
  output pwmts_pkg::pwmts_pin_s             pwm_pin_c,
  output pwmts_pkg::pwmts_pin_s             pwm_pin_d,
  output logic                              compare_match_a_request,
  output logic      [pwmts_pkg::IRQ_LVL_W-1:0] irq_priority
);

  localparam int CW = pwmts_pkg::CNT_W;
  localparam int RW = pwmts_pkg::REG_W;

  // whole block state
  typedef struct packed {
    logic                         ack;
    logic [pwmts_pkg::DATA_W-1:0] rdata;
    logic [CW-1:0]                cnt;
    logic [CW-1:0]                period;
    logic [CW-1:0]                chg_b;
    logic [CW-1:0]                chg_c;
    logic [CW-1:0]                chg_d;
    logic [RW-1:0]                ctrl;
    logic [RW-1:0]                dis1;
    logic [RW-1:0]                dis2;
    logic [RW-1:0]                status;
    logic [RW-1:0]                seen;
    logic [RW-1:0]                ien;
    logic [RW-1:0]                pol;
    logic [RW-1:0]                init;
    logic [pwmts_pkg::IRQ_LVL_W-1:0] lvl;
    logic                         go;
    logic                         go_d;
    logic [DIV_W-1:0]             div;
    logic                         pin_a_lvl;
    logic                         pin_a_oe;
    logic                         irq;
  } pwmts_core_s;

  pwmts_core_s state_reg;
  pwmts_core_s state_next;

  logic                         cutoff_sync_n;
  logic                         cut;
  logic                         tick;
  logic                         restart;
  logic                         period_hit;
  logic                         clear_hit;
  logic                         wrap_hit;
  logic                         hit_b;
  logic                         hit_c;
  logic                         hit_d;
  logic [DIV_W-1:0]             div_mask;
  logic [pwmts_pkg::SRC_W-1:0]  src_sel;
  logic [pwmts_pkg::CLR_W-1:0]  clr_sel;
  logic [RW-1:0]                flag_set;
  logic [pwmts_pkg::DATA_W-1:0] rd_mux;
  logic                         bus_req;
  logic                         wr_take;
  logic                         rd_take;
  pwmts_pkg::pwmts_chan_cfg_s   cfg_b;
  pwmts_pkg::pwmts_chan_cfg_s   cfg_c;
  pwmts_pkg::pwmts_chan_cfg_s   cfg_d;

  // merge a write into a 16-bit register by byte lanes
  function automatic logic [CW-1:0] merge16(
    input logic [CW-1:0]                old_val,
    input logic [pwmts_pkg::DATA_W-1:0] wdata,
    input logic [pwmts_pkg::BE_W-1:0]   be
  );
    logic [CW-1:0] res;
    res = old_val;
    if (be[0]) begin
      res[7:0] = wdata[7:0];
    end
    if (be[1]) begin
      res[15:8] = wdata[15:8];
    end
    return res;
  endfunction

  // merge a write into an 8-bit register on lane 0
  function automatic logic [RW-1:0] merge8(
    input logic [RW-1:0]                old_val,
    input logic [pwmts_pkg::DATA_W-1:0] wdata,
    input logic [pwmts_pkg::BE_W-1:0]   be
  );
    logic [RW-1:0] res;
    res = old_val;
    if (be[0]) begin
      res = wdata[RW-1:0];
    end
    return res;
  endfunction

  // cutoff pin crosses into the clock domain
  pwmts_sync2 #(
    .W (1)
  ) u_cutoff_sync (
    .clock    (clock),
    .srst     (srst),
    .async_in (external_cutoff_input_n),
    .sync_out (cutoff_sync_n)
  );

  // cutoff only acts while its gate bit is set
  assign cut = ~cutoff_sync_n & state_reg.dis2[pwmts_pkg::CUTOFF_GATE_BIT];  // RULE4

  // count source: f1 divided by 2 to the power of the source field
  assign src_sel  = state_reg.ctrl[pwmts_pkg::SRC_LSB +: pwmts_pkg::SRC_W];
  assign clr_sel  = state_reg.ctrl[pwmts_pkg::CLR_LSB +: pwmts_pkg::CLR_W];
  assign div_mask = ~({DIV_W{1'b1}} << src_sel);
  assign restart  = state_reg.go & ~state_reg.go_d;
  assign tick     = state_reg.go & ~restart
                    & ((state_reg.div & div_mask) == div_mask);  // RULE7

  // period compare and wrap detection
  assign period_hit = tick & (state_reg.cnt == state_reg.period);
  assign clear_hit  = period_hit & (clr_sel == pwmts_pkg::CLR_SEL_PERIOD);  // RULE11
  assign wrap_hit   = tick & ~clear_hit & (state_reg.cnt == pwmts_pkg::CNT_TOP);  // RULE10

  // per-channel configuration
  always_comb begin
    cfg_b.polarity    = state_reg.pol[pwmts_pkg::POL_B_BIT];
    cfg_b.init_level  = state_reg.init[pwmts_pkg::INIT_B_BIT];
    cfg_b.disable_out = state_reg.dis1[pwmts_pkg::DIS_B_BIT];  // RULE3
    cfg_b.cutoff      = cut;
    cfg_c.polarity    = state_reg.pol[pwmts_pkg::POL_C_BIT];
    cfg_c.init_level  = state_reg.init[pwmts_pkg::INIT_C_BIT];
    cfg_c.disable_out = state_reg.dis1[pwmts_pkg::DIS_C_BIT];  // RULE3
    cfg_c.cutoff      = cut;
    cfg_d.polarity    = state_reg.pol[pwmts_pkg::POL_D_BIT];
    cfg_d.init_level  = state_reg.init[pwmts_pkg::INIT_D_BIT];
    cfg_d.disable_out = state_reg.dis1[pwmts_pkg::DIS_D_BIT];  // RULE3
    cfg_d.cutoff      = cut;
  end

  // the three pwm outputs
  pwmts_pwm_chan #(
    .CNT_W (CW)
  ) u_chan_b (
    .clock      (clock),
    .srst       (srst),
    .tick       (tick),
    .restart    (restart),
    .period_hit (period_hit),
    .counter    (state_reg.cnt),
    .change_val (state_reg.chg_b),
    .cfg        (cfg_b),
    .pin        (pwm_pin_b),
    .change_hit (hit_b)
  );

  pwmts_pwm_chan #(
    .CNT_W (CW)
  ) u_chan_c (
    .clock      (clock),
    .srst       (srst),
    .tick       (tick),
    .restart    (restart),
    .period_hit (period_hit),
    .counter    (state_reg.cnt),
    .change_val (state_reg.chg_c),
    .cfg        (cfg_c),
    .pin        (pwm_pin_c),
    .change_hit (hit_c)
  );

  pwmts_pwm_chan #(
    .CNT_W (CW)
  ) u_chan_d (
    .clock      (clock),
    .srst       (srst),
    .tick       (tick),
    .restart    (restart),
    .period_hit (period_hit),
    .counter    (state_reg.cnt),
    .change_val (state_reg.chg_d),  // RULE1
    .cfg        (cfg_d),
    .pin        (pwm_pin_d),
    .change_hit (hit_d)
  );

  // hardware flag events
  always_comb begin
    flag_set = '0;
    flag_set[pwmts_pkg::FLAG_A_BIT]    = period_hit;  // RULE15
    flag_set[pwmts_pkg::FLAG_B_BIT]    = hit_b;
    flag_set[pwmts_pkg::FLAG_C_BIT]    = hit_c;
    flag_set[pwmts_pkg::FLAG_D_BIT]    = hit_d;
    flag_set[pwmts_pkg::FLAG_WRAP_BIT] = wrap_hit;  // RULE10
  end

  // register read multiplexer; unmapped addresses read zero
  always_comb begin
    rd_mux = '0;
    case (avs_address)
      pwmts_pkg::OFS_START: begin
        rd_mux[pwmts_pkg::START_GO_BIT] = state_reg.go;
      end
      pwmts_pkg::OFS_STATUS:  rd_mux[RW-1:0] = state_reg.status;
      pwmts_pkg::OFS_IEN:     rd_mux[RW-1:0] = state_reg.ien;
      pwmts_pkg::OFS_IRQC: begin
        rd_mux[pwmts_pkg::IRQ_LVL_LSB +: pwmts_pkg::IRQ_LVL_W] = state_reg.lvl;
        rd_mux[pwmts_pkg::IRQ_PEND_BIT] = state_reg.irq;  // RULE8
      end
      pwmts_pkg::OFS_DIS1:    rd_mux[RW-1:0] = state_reg.dis1;
      pwmts_pkg::OFS_DIS2:    rd_mux[RW-1:0] = state_reg.dis2;
      pwmts_pkg::OFS_COUNTER: rd_mux[CW-1:0] = state_reg.cnt;
      pwmts_pkg::OFS_PERIOD:  rd_mux[CW-1:0] = state_reg.period;
      pwmts_pkg::OFS_CHG_B:   rd_mux[CW-1:0] = state_reg.chg_b;
      pwmts_pkg::OFS_CHG_C:   rd_mux[CW-1:0] = state_reg.chg_c;
      pwmts_pkg::OFS_CHG_D:   rd_mux[CW-1:0] = state_reg.chg_d;  // RULE1
      pwmts_pkg::OFS_CTRL:    rd_mux[RW-1:0] = state_reg.ctrl;
      pwmts_pkg::OFS_POL:     rd_mux[RW-1:0] = state_reg.pol;
      pwmts_pkg::OFS_INIT:    rd_mux[RW-1:0] = state_reg.init;
      default:                rd_mux = '0;
    endcase
  end

  // every access waits exactly one cycle, then completes
  assign bus_req = avs_read | avs_write;
  assign wr_take = avs_write & state_reg.ack;
  assign rd_take = avs_read & state_reg.ack;

  // next-state logic: bus, counter, flags, pins
  always_comb begin
    state_next      = state_reg;
    state_next.ack  = bus_req & ~state_reg.ack;
    state_next.go_d = state_reg.go;
    if (avs_read & ~state_reg.ack) begin
      state_next.rdata = rd_mux;
    end

    // prescaler runs while counting, restarts with the counter
    if (restart | ~state_reg.go) begin
      state_next.div = '0;
    end else begin
      state_next.div = state_reg.div + 1'b1;
    end

    // counter: clear on period match when clear select is 001, else increment and wrap
    if (clear_hit) begin
      state_next.cnt = pwmts_pkg::CNT_RST;  // RULE11
    end else if (tick) begin
      state_next.cnt = state_reg.cnt + 1'b1;  // RULE10
    end

    // period pin toggles on every period match, whether or not it is released
    if (restart) begin
      state_next.pin_a_lvl = 1'b0;
    end else if (period_hit) begin
      state_next.pin_a_lvl = ~state_reg.pin_a_lvl;
    end
    state_next.pin_a_oe = ~state_reg.dis1[pwmts_pkg::DIS_A_BIT] & ~cut;  // RULE2

    // a status read remembers which flags were seen set
    if (rd_take && avs_address == pwmts_pkg::OFS_STATUS) begin
      state_next.seen = state_reg.status;  // RULE5
    end

    // register writes take effect on the completing edge
    if (wr_take) begin
      case (avs_address)
        pwmts_pkg::OFS_START: begin
          if (avs_byteenable[0]) begin
            state_next.go = avs_writedata[pwmts_pkg::START_GO_BIT];  // RULE7
          end
        end
        pwmts_pkg::OFS_STATUS: begin
          if (avs_byteenable[0]) begin
            // clear only bits written 0 that were read as 1
            state_next.status = state_reg.status
                                & ~(~avs_writedata[RW-1:0] & state_reg.seen);  // RULE5
            state_next.seen   = state_reg.seen & avs_writedata[RW-1:0];
          end
        end
        pwmts_pkg::OFS_IEN: begin
          state_next.ien = merge8(state_reg.ien, avs_writedata, avs_byteenable);
        end
        pwmts_pkg::OFS_IRQC: begin
          if (avs_byteenable[0]) begin
            state_next.lvl = avs_writedata[pwmts_pkg::IRQ_LVL_LSB +: pwmts_pkg::IRQ_LVL_W];
          end
        end
        pwmts_pkg::OFS_DIS1: begin
          state_next.dis1 = merge8(state_reg.dis1, avs_writedata, avs_byteenable);
        end
        pwmts_pkg::OFS_DIS2: begin
          state_next.dis2 = merge8(state_reg.dis2, avs_writedata, avs_byteenable);
        end
        pwmts_pkg::OFS_COUNTER: begin
          state_next.cnt = merge16(state_reg.cnt, avs_writedata, avs_byteenable);
        end
        pwmts_pkg::OFS_PERIOD: begin
          state_next.period = merge16(state_reg.period, avs_writedata, avs_byteenable);
        end
        pwmts_pkg::OFS_CHG_B: begin
          state_next.chg_b = merge16(state_reg.chg_b, avs_writedata, avs_byteenable);
        end
        pwmts_pkg::OFS_CHG_C: begin
          state_next.chg_c = merge16(state_reg.chg_c, avs_writedata, avs_byteenable);
        end
        pwmts_pkg::OFS_CHG_D: begin
          state_next.chg_d = merge16(state_reg.chg_d, avs_writedata, avs_byteenable);  // RULE1
        end
        pwmts_pkg::OFS_CTRL: begin
          state_next.ctrl = merge8(state_reg.ctrl, avs_writedata, avs_byteenable);
        end
        pwmts_pkg::OFS_POL: begin
          state_next.pol = merge8(state_reg.pol, avs_writedata, avs_byteenable);
        end
        pwmts_pkg::OFS_INIT: begin
          state_next.init = merge8(state_reg.init, avs_writedata, avs_byteenable);
        end
        default: begin
          state_next.go = state_reg.go;  // unmapped writes are dropped
        end
      endcase
    end

    // new events win over a clear in the same cycle
    state_next.status = (state_next.status | flag_set) & pwmts_pkg::FLAG_MASK;

    // an active cutoff forces every pin disable bit to 1
    if (cut) begin
      state_next.dis1 = state_next.dis1 | pwmts_pkg::DIS_PWM_MASK;  // RULE4
    end

    // level interrupt from any enabled flag
    state_next.irq = |(state_next.status & state_next.ien & pwmts_pkg::FLAG_MASK);  // RULE6
  end

  // one register for the whole state
  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg        <= '0;
      state_reg.rdata  <= pwmts_pkg::RDATA_RST;
      state_reg.cnt    <= pwmts_pkg::CNT_RST;
      state_reg.period <= pwmts_pkg::CMP_RST;
      state_reg.chg_b  <= pwmts_pkg::CMP_RST;
      state_reg.chg_c  <= pwmts_pkg::CMP_RST;
      state_reg.chg_d  <= pwmts_pkg::CMP_RST;
      state_reg.ctrl   <= pwmts_pkg::CTRL_RST;
      state_reg.dis1   <= pwmts_pkg::DIS1_RST;
      state_reg.dis2   <= pwmts_pkg::REG8_RST;
      state_reg.status <= pwmts_pkg::REG8_RST;
      state_reg.seen   <= pwmts_pkg::REG8_RST;
      state_reg.ien    <= pwmts_pkg::REG8_RST;
      state_reg.pol    <= pwmts_pkg::POL_RST;
      state_reg.init   <= pwmts_pkg::REG8_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs
  assign avs_readdata            = state_reg.rdata;
  assign avs_waitrequest         = bus_req & ~state_reg.ack;
  assign period_pin              = {state_reg.pin_a_lvl, state_reg.pin_a_oe};  // RULE2
  assign compare_match_a_request = state_reg.irq;  // RULE6
  assign irq_priority            = state_reg.lvl;  // RULE8

endmodule

// ### pwmts_checker.sv
// pwmts_checker: bus handshake, pin enable and irq checks for pwmts_top.
// assumes it is bound into pwmts_top and sees only its ports.
`timescale 1ns/10ps
module pwmts_checker (
  input wire logic                  clock,
  input wire logic                  srst,
  input wire logic [5:0]            avs_address,
  input wire logic                  avs_read,
  input wire logic                  avs_write,
  input wire logic [31:0]           avs_writedata,
  input wire logic [3:0]            avs_byteenable,
  input wire logic [31:0]           avs_readdata,
  input wire logic                  avs_waitrequest,
  input wire pwmts_pkg::pwmts_pin_s period_pin,
  input wire pwmts_pkg::pwmts_pin_s pwm_pin_b,
  input wire pwmts_pkg::pwmts_pin_s pwm_pin_d,
  input wire logic                  compare_match_a_request,
  input wire logic [2:0]            irq_priority
);
  logic rq;
  logic wr_done;
  logic dis_wr;
  // request seen, write completing, disable write completing
  assign rq      = avs_read | avs_write;
  assign wr_done = avs_write & ~avs_waitrequest & avs_byteenable[0];
  assign dis_wr  = wr_done && avs_address == pwmts_pkg::OFS_DIS1;
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  wait_first_a: assert property (rq && !$past(rq) |-> avs_waitrequest)
    else $error("no wait in first request cycle");
  wait_one_a: assert property (avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait cycle");
  idle_nowait_a: assert property (!rq |-> !avs_waitrequest)
    else $error("wait raised while idle");
  rdata_hold_a: assert property ($changed(avs_readdata) |-> $past(avs_read))
    else $error("read data moved without a read");
  pin_a_off_a: assert property (dis_wr && avs_writedata[0] |-> ##[1:3] !period_pin.oe)
    else $error("period pin still driven");
  pin_b_off_a: assert property (dis_wr && avs_writedata[1] |-> ##[1:3] !pwm_pin_b.oe)
    else $error("pin b still driven");
  pin_d_off_a: assert property (dis_wr && avs_writedata[3] |-> ##[1:3] !pwm_pin_d.oe)
    else $error("pin d still driven");
  prio_load_a: assert property (wr_done && avs_address == pwmts_pkg::OFS_IRQC
    |-> ##2 irq_priority == $past(avs_writedata[2:0], 2)) else $error("priority not loaded");
  rst_quiet_a: assert property ($fell(srst) |-> !period_pin.oe && !pwm_pin_b.oe
    && !compare_match_a_request && irq_priority == 3'h0) else $error("outputs not quiet");
endmodule
bind pwmts_top pwmts_checker i_chk (.clock, .srst, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .period_pin,
  .pwm_pin_b, .pwm_pin_d, .compare_match_a_request, .irq_priority);

// ### pwm_timer_output_setup_bench.sv
// pwm_timer_output_setup_bench: register and pwm sequence tests for pwmts_top.
// assumes the checker is bound in and a 100 MHz clock.
`timescale 1ns/10ps
module pwm_timer_output_setup_bench;
  logic clock, srst, avs_read, avs_write, avs_waitrequest, external_cutoff_input_n;
  logic compare_match_a_request;
  logic [5:0]  avs_address;
  logic [3:0]  avs_byteenable;
  logic [2:0]  irq_priority;
  logic [31:0] avs_writedata, avs_readdata, q, q0, nb, nc, nd;
  pwmts_pkg::pwmts_pin_s period_pin, pwm_pin_b, pwm_pin_c, pwm_pin_d;
  int n_mismatch, check_count;
  pwmts_top i_dut (.clock, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .external_cutoff_input_n,
    .period_pin, .pwm_pin_b, .pwm_pin_c, .pwm_pin_d, .compare_match_a_request, .irq_priority);
  // clock source
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  // counts, verdict and end of run
  task automatic results;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // one avalon access, held until wait is seen low at a rising edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 50) begin
      n_mismatch++;
      results();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(negedge clock);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [5:0] a);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  // active cycles of the three pwm pins over two periods
  task automatic span;
    nb = 0;
    nc = 0;
    nd = 0;
    repeat (16) begin
      @(negedge clock);
      nb = nb + pwm_pin_b.out;
      nc = nc + pwm_pin_c.out;
      nd = nd + pwm_pin_d.out;
    end
  endtask
  // main sequence
  initial begin
    srst = 1;
    avs_read = 0;
    avs_write = 0;
    avs_address = 0;
    avs_writedata = 0;
    avs_byteenable = 4'hF;
    external_cutoff_input_n = 1;
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    rd(pwmts_pkg::OFS_DIS1); chk(q, 32'h0000_000F);
    rd(pwmts_pkg::OFS_CHG_D); chk(q, 32'h0000_FFFF);
    rd(6'h3C); chk(q, 32'h0000_0000);
    wr(pwmts_pkg::OFS_CHG_D, 32'h0000_05DB);
    rd(pwmts_pkg::OFS_CHG_D); chk(q, 32'h0000_05DB);
    wr(pwmts_pkg::OFS_IRQC, 32'h0000_000F);
    rd(pwmts_pkg::OFS_IRQC); chk(q, 32'h0000_0007);
    wr(pwmts_pkg::OFS_IRQC, 32'h0000_0001);
    chk({29'h0, irq_priority}, 32'h0000_0001);
    // period 8 cycles, change points 1, 3 and 5
    wr(pwmts_pkg::OFS_DIS1, 32'h0000_000F);
    wr(pwmts_pkg::OFS_PERIOD, 32'h0000_0007);
    wr(pwmts_pkg::OFS_CHG_B, 32'h0000_0001);
    wr(pwmts_pkg::OFS_CHG_C, 32'h0000_0003);
    wr(pwmts_pkg::OFS_CHG_D, 32'h0000_0005);
    wr(pwmts_pkg::OFS_DIS1, 32'h0000_0001);
    wr(pwmts_pkg::OFS_IEN, 32'h0000_0001);
    wr(pwmts_pkg::OFS_START, 32'h0000_0001);
    repeat (20) @(negedge clock);
    span();
    chk(nb, 32'h0000_000C);
    chk(nc, 32'h0000_0008);
    chk(nd, 32'h0000_0004);
    chk({pwm_pin_b.oe, pwm_pin_c.oe, pwm_pin_d.oe, period_pin.oe}, 32'h0000_000E);
    // cutoff ignored while its gate is off
    @(posedge clock);
    external_cutoff_input_n <= 1'b0;
    repeat (8) @(negedge clock);
    chk(pwm_pin_b.oe, 32'h0000_0001);
    rd(pwmts_pkg::OFS_DIS1); chk(q, 32'h0000_0001);
    chk(compare_match_a_request, 32'h0000_0001);
    wr(pwmts_pkg::OFS_START, 32'h0000_0000);
    rd(pwmts_pkg::OFS_COUNTER);
    q0 = q;
    rd(pwmts_pkg::OFS_COUNTER); chk(q, q0);
    // flag a survives a zero write with no read before it
    wr(pwmts_pkg::OFS_STATUS, 32'h0000_0000);
    rd(pwmts_pkg::OFS_STATUS); chk(q & 32'h1, 32'h0000_0001);
    wr(pwmts_pkg::OFS_STATUS, 32'h0000_0000);
    rd(pwmts_pkg::OFS_STATUS); chk(q & 32'h1, 32'h0000_0000);
    chk(compare_match_a_request, 32'h0000_0000);
    wr(pwmts_pkg::OFS_IEN, 32'h0000_0000);
    wr(pwmts_pkg::OFS_COUNTER, 32'h0000_FFFF);
    wr(pwmts_pkg::OFS_START, 32'h0000_0001);
    repeat (20) @(negedge clock);
    chk(compare_match_a_request, 32'h0000_0000);
    rd(pwmts_pkg::OFS_STATUS); chk(q & 32'h10, 32'h0000_0010);
    wr(pwmts_pkg::OFS_IEN, 32'h0000_0001);
    repeat (3) @(negedge clock);
    chk(compare_match_a_request, 32'h0000_0001);
    // cutoff obeyed once its gate is on
    wr(pwmts_pkg::OFS_DIS2, 32'h0000_0080);
    repeat (8) @(negedge clock);
    rd(pwmts_pkg::OFS_DIS1); chk(q, 32'h0000_000F);
    chk(pwm_pin_b.oe, 32'h0000_0000);
    results();
  end
endmodule
